//--- rtl/gpio_ports.v
// bidirectional i/o ports: output latches, direction registers, pin readback
//
// Operation
// - port reads return live pin levels
// - reset makes every pin an input
// - first port four bits, upper read zero
// - second port is eight full pins
// - third location port or plain storage
// - direction load copies working register value
// - one tristates pin, zero drives latch
// - direction write-only, all ones on reset
// - output latch holds until rewritten
// - every pin direction set independently
// - output latches untouched by any reset
`timescale 1ns/10ps
`include "gpio_defines.vh"
module gpio_ports #(
   parameter HAS_THIRD_PORT = 1
) (
   // clock and reset
   input wire CLK,
   input wire RESET_N,
   // register access from the core
   input wire [4:0] ADDR,
   input wire WR_EN,
   input wire [7:0] WR_DATA,
   input wire RD_EN,
   output reg [7:0] RD_DATA,
   // direction load from working register
   input wire DIR_LOAD,
   input wire [1:0] DIR_SEL,
   input wire [7:0] WREG,
   // first port pins
   input wire [3:0] FIRST_PORT_PIN_BITS_I,
   output reg [3:0] FIRST_PORT_PIN_BITS_O,
   output reg [3:0] FIRST_PORT_PIN_BITS_OE,
   // second port pins
   input wire [7:0] SECOND_PORT_PIN_BITS_I,
   output reg [7:0] SECOND_PORT_PIN_BITS_O,
   output reg [7:0] SECOND_PORT_PIN_BITS_OE,
   // third port pins
   input wire [7:0] THIRD_PORT_PIN_BITS_I,
   output reg [7:0] THIRD_PORT_PIN_BITS_O,
   output reg [7:0] THIRD_PORT_PIN_BITS_OE
);
   reg [3:0] first_latch_q;
   reg [7:0] second_latch_q;
   reg [7:0] third_latch_q;
   reg [3:0] first_dir_q;
   reg [7:0] second_dir_q;
   reg [7:0] third_dir_q;
   reg [7:0] rd_data_d;
   wire [7:0] store_rd;
   wire store_wr;

   // -------------------------------------------------------------
   // output latches
   // -------------------------------------------------------------
   // no reset term: power-on contents are unknown, later resets keep them
   always @(posedge CLK) begin
      if (WR_EN && ADDR == `GPIO_ADDR_FIRST) begin
         first_latch_q <= WR_DATA[3:0];
      end
      if (WR_EN && ADDR == `GPIO_ADDR_SECOND) begin
         second_latch_q <= WR_DATA;
      end
      if (HAS_THIRD_PORT != 0 && WR_EN && ADDR == `GPIO_ADDR_THIRD) begin
         third_latch_q <= WR_DATA;
      end
   end

   // -------------------------------------------------------------
   // direction registers
   // -------------------------------------------------------------
   always @(posedge CLK) begin
      if (!RESET_N) begin
         first_dir_q <= `GPIO_DIR_RESET_FIRST;
         second_dir_q <= `GPIO_DIR_RESET;
         third_dir_q <= `GPIO_DIR_RESET;
      end else if (DIR_LOAD) begin
         case (DIR_SEL)
            `GPIO_SEL_FIRST: begin
               first_dir_q <= WREG[3:0];
            end
            `GPIO_SEL_SECOND: begin
               second_dir_q <= WREG;
            end
            `GPIO_SEL_THIRD: begin
               if (HAS_THIRD_PORT != 0) begin
                  third_dir_q <= WREG;
               end
            end
            default: begin
               first_dir_q <= first_dir_q;
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // pin drivers
   // -------------------------------------------------------------
   // registered so the outputs come from flops; pins follow one cycle later
   always @(posedge CLK) begin
      if (!RESET_N) begin
         FIRST_PORT_PIN_BITS_OE <= 4'h0;
         SECOND_PORT_PIN_BITS_OE <= 8'h00;
         THIRD_PORT_PIN_BITS_OE <= 8'h00;
         FIRST_PORT_PIN_BITS_O <= 4'h0;
         SECOND_PORT_PIN_BITS_O <= 8'h00;
         THIRD_PORT_PIN_BITS_O <= 8'h00;
      end else begin
         FIRST_PORT_PIN_BITS_OE <= ~first_dir_q;
         SECOND_PORT_PIN_BITS_OE <= ~second_dir_q;
         THIRD_PORT_PIN_BITS_OE <= (HAS_THIRD_PORT != 0) ? ~third_dir_q : 8'h00;
         FIRST_PORT_PIN_BITS_O <= first_latch_q;
         SECOND_PORT_PIN_BITS_O <= second_latch_q;
         THIRD_PORT_PIN_BITS_O <= (HAS_THIRD_PORT != 0) ? third_latch_q : 8'h00;
      end
   end

   // -------------------------------------------------------------
   // storage for the third location on small variants
   // -------------------------------------------------------------
   assign store_wr = (HAS_THIRD_PORT == 0) && WR_EN && ADDR == `GPIO_ADDR_THIRD;

   gpio_store u_store (
      .clk(CLK),
      .wr_en(store_wr),
      .wr_data(WR_DATA),
      .rd_data(store_rd)
   );

   // -------------------------------------------------------------
   // read path
   // -------------------------------------------------------------
   // pins are not latched; outside must hold levels through the read
   always @* begin
      rd_data_d = 8'h00;
      case (ADDR)
         `GPIO_ADDR_FIRST: begin
            rd_data_d = {4'h0, FIRST_PORT_PIN_BITS_I};
         end
         `GPIO_ADDR_SECOND: begin
            rd_data_d = SECOND_PORT_PIN_BITS_I;
         end
         `GPIO_ADDR_THIRD: begin
            rd_data_d = (HAS_THIRD_PORT != 0) ? THIRD_PORT_PIN_BITS_I : store_rd;
         end
         default: begin
            rd_data_d = 8'h00;
         end
      endcase
   end

   // direction registers have no read path at all
   always @(posedge CLK) begin
      if (!RESET_N) begin
         RD_DATA <= 8'h00;
      end else if (RD_EN) begin
         RD_DATA <= rd_data_d;
      end
   end
endmodule

//--- rtl/gpio_defines.vh
// register offsets, direction select codes, first port width and reset values for the i/o port block
`ifndef GPIO_DEFINES_VH
`define GPIO_DEFINES_VH
`define GPIO_ADDR_FIRST 5'h05
`define GPIO_ADDR_SECOND 5'h06
`define GPIO_ADDR_THIRD 5'h07
`define GPIO_DIR_RESET 8'hff
`define GPIO_DIR_RESET_FIRST 4'hf
`define GPIO_FIRST_WIDTH 4
`define GPIO_SEL_FIRST 2'h0
`define GPIO_SEL_SECOND 2'h1
`define GPIO_SEL_THIRD 2'h2
`endif

//--- rtl/gpio_store.v
// one-byte storage cell used as the third location on small variants
`timescale 1ns/10ps
module gpio_store (
   // clock
   input wire clk,
   // write side
   input wire wr_en,
   input wire [7:0] wr_data,
   // read side
   output reg [7:0] rd_data
);
   reg [7:0] mem_q;

   // no reset: contents survive every reset like other general storage
   always @(posedge clk) begin
      if (wr_en) begin
         mem_q <= wr_data;
      end
   end

   always @(posedge clk) begin
      rd_data <= wr_en ? wr_data : mem_q;
   end
endmodule

//--- verif/bio_assertions.sv
// concurrent checks on the i/o port block
`timescale 1ns/10ps
module bio_checker (
   input wire CLK, RESET_N, WR_EN, RD_EN, DIR_LOAD,
   input wire [4:0] ADDR,
   input wire [1:0] DIR_SEL,
   input wire [7:0] WR_DATA, RD_DATA, WREG, SECOND_PORT_PIN_BITS_I,
   input wire [7:0] SECOND_PORT_PIN_BITS_O, SECOND_PORT_PIN_BITS_OE,
   input wire [3:0] FIRST_PORT_PIN_BITS_I
);
   wire w2 = WR_EN && ADDR == 5'h06;
   wire d2 = DIR_LOAD && DIR_SEL == 2'h1;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   chk_reset_in: assert property ($rose(RESET_N) |-> !SECOND_PORT_PIN_BITS_OE)
      else $error("oe on");
   chk_dir_load: assert property (d2 |=> ##1 SECOND_PORT_PIN_BITS_OE == ~$past(WREG, 2))
      else $error("oe");
   chk_read_pins: assert property (RD_EN && ADDR == 5'h06 |=>
      RD_DATA == $past(SECOND_PORT_PIN_BITS_I))
      else $error("rd");
   chk_first_upper: assert property (RD_EN && ADDR == 5'h05 |=>
      RD_DATA == {4'h0, $past(FIRST_PORT_PIN_BITS_I)})
      else $error("rd first");
   chk_latch_out: assert property (w2 |=> ##1 SECOND_PORT_PIN_BITS_O == $past(WR_DATA, 2))
      else $error("latch");
   chk_latch_hold: assert property ($changed(SECOND_PORT_PIN_BITS_O) |->
      $past(w2, 2) || !$past(RESET_N, 2))
      else $error("o moved");
   chk_dir_hold: assert property ($changed(SECOND_PORT_PIN_BITS_OE) |->
      $past(d2, 2) || !$past(RESET_N, 2))
      else $error("oe moved");
   chk_read_hold: assert property (!RD_EN |=> $stable(RD_DATA))
      else $error("rd moved");
   cover property (DIR_LOAD && DIR_SEL == 2'h3);
   cover property (w2);
   cover property (RD_EN && ADDR == 5'h05);
endmodule
bind gpio_ports bio_checker chk_i (.*);

//--- verif/bio_pins.sv
// outside circuitry holding levels on one port's pins
`timescale 1ns/10ps
module bio_pins #(parameter W = 8) (
   input wire [W-1:0] o, oe, drv,
   output wire [W-1:0] pin
);
   // outside keeps its level on inputs until read
   assign pin = (oe & o) | (~oe & drv);
endmodule

//--- verif/bidirectional_io_ports_bench.sv
// self-checking bench for the i/o port block
`timescale 1ns/10ps
module bidirectional_io_ports_bench;
   reg CLK = 0, RESET_N = 0, WR_EN = 0, RD_EN = 0, DIR_LOAD = 0, rv = 0;
   reg [4:0] ADDR = 0;
   reg [1:0] DIR_SEL = 0;
   reg [7:0] WR_DATA = 0, WREG = 0, m, k, drv [0:2], lat [0:2];
   wire [7:0] RD_DATA, SECOND_PORT_PIN_BITS_I, SECOND_PORT_PIN_BITS_O, SECOND_PORT_PIN_BITS_OE;
   wire [7:0] THIRD_PORT_PIN_BITS_I, THIRD_PORT_PIN_BITS_O, THIRD_PORT_PIN_BITS_OE;
   wire [3:0] FIRST_PORT_PIN_BITS_I, FIRST_PORT_PIN_BITS_O, FIRST_PORT_PIN_BITS_OE;
   integer seed = 32'hb016bae5, err_total = 0, compares = 0, cyc_n = 0, p;
   logic [7:0] exp_q [$];
   gpio_ports uut (.*);
   bio_pins #(.W(4)) pf (.o(FIRST_PORT_PIN_BITS_O), .oe(FIRST_PORT_PIN_BITS_OE),
      .drv(drv[0][3:0]), .pin(FIRST_PORT_PIN_BITS_I));
   bio_pins ps (.o(SECOND_PORT_PIN_BITS_O), .oe(SECOND_PORT_PIN_BITS_OE), .drv(drv[1]),
      .pin(SECOND_PORT_PIN_BITS_I));
   bio_pins pt (.o(THIRD_PORT_PIN_BITS_O), .oe(THIRD_PORT_PIN_BITS_OE), .drv(drv[2]),
      .pin(THIRD_PORT_PIN_BITS_I));
   initial forever #12.5 CLK = ~CLK;
   task chk(input [7:0] s, input [7:0] e);
      compares = compares + 1;
      if (s !== e) begin
         err_total = err_total + 1;
         $display("unexpected RD_DATA expected %h seen %h", e, s);
      end
   endtask
   task final_report;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // f: load, read, write strobes; read expectations queued here
   task bus(input [2:0] f, input [4:0] a, input [7:0] d, input [7:0] e);
      @(negedge CLK);
      {DIR_LOAD, RD_EN, WR_EN} = f;
      ADDR = a;
      DIR_SEL = a[1:0];
      WR_DATA = d;
      WREG = d;
      if (f[1]) exp_q.push_back(e);
      @(negedge CLK);
      {DIR_LOAD, RD_EN, WR_EN} = 3'h0;
   endtask
   always @(posedge CLK) rv <= RD_EN && RESET_N;
   always @(negedge CLK) if (rv) chk(RD_DATA, exp_q.pop_front());
   always @(posedge CLK) begin
      cyc_n = cyc_n + 1;
      if (cyc_n == 1000) begin
         err_total = err_total + 1;
         final_report;
      end
   end
   initial begin
      for (p = 0; p < 3; p = p + 1) drv[p] = 8'h00;
      repeat (12) @(negedge CLK);
      RESET_N = 1;
      for (p = 0; p < 3; p = p + 1) begin
         k = p ? 8'hff : 8'h0f;
         drv[p] = $random(seed);
         lat[p] = $random(seed);
         m = $random(seed);
         bus(3'h2, 5'h05 + p, 8'h00, drv[p] & k);
         bus(3'h1, 5'h05 + p, lat[p], 8'h00);
         bus(3'h2, 5'h05 + p, 8'h00, drv[p] & k);
         bus(3'h4, p, m, 8'h00);
         bus(3'h4, 5'h03, 8'h00, 8'h00);
         bus(3'h2, 5'h05 + p, 8'h00, ((lat[p] & ~m) | (drv[p] & m)) & k);
      end
      bus(3'h2, 5'h1f, 8'h00, 8'h00);
      RESET_N = 0;
      repeat (2) @(negedge CLK);
      RESET_N = 1;
      bus(3'h2, 5'h06, 8'h00, drv[1]);
      bus(3'h4, 5'h01, 8'h00, 8'h00);
      bus(3'h2, 5'h06, 8'h00, lat[1]);
      repeat (3) @(negedge CLK);
      final_report;
   end
endmodule
